// [design/uhd_global_ctrl.sv]
// global control and status slice of a high-speed usb device
// assumes a same-clock packet decoder feeding sof, reset and token
// strobes; only the line wake level arrives asynchronously
`timescale 1ns/1ps
`include "uhd_consts.svh"

// Summary of operation
// - address reads zero after reset and bus reset
// - accept stored address if valid, else zero
// - address_valid cleared on reset and bus reset
// - controller_enable bit enables or disables controller
// - soft_detach suspends transceiver, clear attaches pull-up
// - writing one requests remote wakeup, zero ignored
// - resume only after five ms of suspend
// - wakeup request self-clears when resume ends
// - line_pulldown_off removes both line pull-downs
// - pulldown off plus detach leaves lines floating
// - microframe index counts 0..7, zeroed per frame
// - frame index holds last frame number received without crc error
// - crc error flag updates with the sof flag
// - enable bits 1..7 gate the bus events
// - bus reset sets end-of-reset enable itself
// - enable bits 8..14 gate endpoints 0..6
// - dma enable bits gate channels 1..6
// - interrupt asserts for any enabled set flag
// - flags cleared only by writing one to clear
module uhd_global_ctrl
  import uhd_pkg::*;
#(
  parameter int unsigned SUSP_WAIT_CYC  = `UHD_SUSP_CYC,   // suspend time before resume
  parameter int unsigned RESUME_K_CYC   = `UHD_RESUME_CYC  // length of the k state
)(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bus_reset_done,
  input  wire logic        bus_suspended,
  input  wire logic        high_speed,
  input  wire logic        sof_valid,
  input  wire logic        sof_first,
  input  wire logic [10:0] sof_frame,
  input  wire logic        sof_crc_err,
  input  wire logic        resume_done,
  input  wire logic        line_wake_async,
  input  wire logic [6:0]  token_addr,
  input  wire logic [6:0]  endpoint_irq,
  input  wire logic [5:0]  dma_irq,
  output wire logic        addr_match,
  output wire logic        controller_enable,
  output wire logic        xcvr_suspend,
  output wire logic        dp_pullup,
  output wire logic        dp_pulldown,
  output wire logic        dm_pulldown,
  output wire logic        resume_k,
  output logic             irq
);
  localparam logic [23:0] SUSP_W = 24'(SUSP_WAIT_CYC);
  localparam logic [23:0] K_LAST = 24'(RESUME_K_CYC - 1);

  // counters are 24 bits wide; both times must fit and be nonzero
  if (SUSP_WAIT_CYC < 1 || SUSP_WAIT_CYC > 24'hFF_FFFF ||
      RESUME_K_CYC < 1 || RESUME_K_CYC > 24'hFF_FFFF) begin : g_bad_time
    $error("uhd_global_ctrl: timing parameter out of range");
  end

  uhd_regbus_if rb ();                  // slave to register file

  logic [11:0] ctrl, next_ctrl;         // device_control bits 11:0
  uhd_word_t   ien, next_ien;           // interrupt_enable
  logic [7:1]  flags, next_flags;       // sticky bus event flags
  logic [10:0] frame_idx, next_frame_idx;
  logic [2:0]  micro_idx, next_micro_idx;
  logic        crc_err, next_crc_err;
  logic        susp_q;                  // suspend level last cycle
  logic        wake_s1, wake_s2, wake_s3; // line wake synchroniser
  uhd_wake_e   wk, next_wk;             // remote wakeup sequencer
  logic [23:0] susp_cnt, next_susp_cnt; // time spent in suspend
  logic [23:0] k_cnt, next_k_cnt;       // time spent driving k
  logic        wake_done;               // request retires
  logic        next_irq;
  logic [7:1]  ev_set, ev_clr;
  uhd_word_t   wmask, stat_rd;
  logic        wr_ctrl, wr_ien, wr_clr;

  function automatic uhd_word_t uhd_bytes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : uhd_bytes

  uhd_axil_slave u_slave (
    .mclk    (mclk),
    .reset   (reset),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rb      (rb)
  );

  // write decode; only lanes with a strobe are touched
  assign wmask   = uhd_bytes(rb.wr_strb);
  assign wr_ctrl = rb.wr_en && rb.wr_addr == `UHD_OFS_CTRL;
  assign wr_ien  = rb.wr_en && rb.wr_addr == `UHD_OFS_IEN;
  assign wr_clr  = rb.wr_en && rb.wr_addr == `UHD_OFS_CLR;
  // frame and status are read-only: writes are dropped without error
  assign rb.wr_err = !(rb.wr_addr inside {`UHD_OFS_CTRL, `UHD_OFS_FRAME,
                       `UHD_OFS_IEN, `UHD_OFS_STAT, `UHD_OFS_CLR});

  // status view; endpoint and dma lines show only when enabled
  assign stat_rd = {1'b0, dma_irq & ien[30:25], 10'h000,
                    endpoint_irq & ien[14:8], flags, high_speed};

  // read mux; reserved bits and the clear register read zero
  always_comb begin
    rb.rd_data = 32'h0000_0000;
    rb.rd_err  = 1'b0;
    unique case (rb.rd_addr)
      `UHD_OFS_CTRL:  rb.rd_data = {20'h00000, ctrl};
      `UHD_OFS_FRAME: rb.rd_data = {crc_err, 17'h00000, frame_idx, micro_idx};
      `UHD_OFS_IEN:   rb.rd_data = ien;
      `UHD_OFS_STAT:  rb.rd_data = stat_rd;
      `UHD_OFS_CLR:   rb.rd_data = 32'h0000_0000;
      default:        rb.rd_err  = 1'b1;
    endcase
  end

  // pins follow the control bits; a pull-down is only used while
  // detached, so it never fights the dp pull-up
  assign controller_enable = ctrl[`UHD_EN_BIT];
  assign xcvr_suspend      = ctrl[`UHD_DETACH_BIT];
  assign dp_pullup         = !ctrl[`UHD_DETACH_BIT];
  assign dp_pulldown       = ctrl[`UHD_DETACH_BIT] && !ctrl[`UHD_PDOFF_BIT];
  assign dm_pulldown       = ctrl[`UHD_DETACH_BIT] && !ctrl[`UHD_PDOFF_BIT];
  assign resume_k          = wk == WK_DRIVE;
  // token filter: default address until firmware validates its own
  assign addr_match = ctrl[`UHD_AVALID_BIT] ? token_addr == ctrl[6:0]
                                            : token_addr == 7'h00;

  // bus events that set sticky flags
  always_comb begin
    ev_set    = 7'h00;
    ev_set[1] = bus_suspended && !susp_q;
    ev_set[2] = sof_valid && !sof_first;
    ev_set[3] = sof_valid && sof_first;
    ev_set[4] = bus_reset_done;
    ev_set[5] = wake_s2 && !wake_s3;
    ev_set[6] = resume_done;
    ev_set[7] = wk == WK_WAIT && bus_suspended && susp_cnt >= SUSP_W;
    ev_clr    = wr_clr ? rb.wr_data[7:1] & wmask[7:1] : 7'h00;
  end

  // register file, frame tracking and interrupt line
  always_comb begin
    next_ctrl      = ctrl;
    next_ien       = ien;
    next_frame_idx = frame_idx;
    next_micro_idx = micro_idx;
    next_crc_err   = crc_err;
    if (wr_ctrl) begin
      next_ctrl = (ctrl & ~wmask[11:0]) | (rb.wr_data[11:0] & wmask[11:0]);
      // a zero write leaves a pending wakeup alone
      next_ctrl[`UHD_RWU_BIT] = ctrl[`UHD_RWU_BIT] |
                                (rb.wr_data[`UHD_RWU_BIT] & wmask[`UHD_RWU_BIT]);
    end
    if (wake_done && !(wr_ctrl && rb.wr_data[`UHD_RWU_BIT] && wmask[`UHD_RWU_BIT])) begin
      next_ctrl[`UHD_RWU_BIT] = 1'b0;
    end
    if (bus_reset_done) begin
      next_ctrl[`UHD_ADDR_MSB:`UHD_ADDR_LSB] = 7'h00;
      next_ctrl[`UHD_AVALID_BIT] = 1'b0;
    end
    if (wr_ien) begin
      next_ien = (ien & ~(wmask & `UHD_IEN_MASK)) |
                 (rb.wr_data & wmask & `UHD_IEN_MASK);
    end
    if (bus_reset_done) begin
      next_ien[`UHD_IEN_RST_BIT] = 1'b1;
    end
    // set beats clear in the same cycle
    next_flags = (flags & ~ev_clr) | ev_set;
    if (!ctrl[`UHD_EN_BIT]) begin
      // disabled controller holds its frame state in reset
      next_frame_idx = 11'h000;
      next_micro_idx = 3'h0;
      next_crc_err   = 1'b0;
    end else if (sof_valid) begin
      next_crc_err = sof_crc_err;
      if (sof_first) begin
        next_micro_idx = 3'h0;
        // a corrupted number is not taken over
        if (!sof_crc_err) begin
          next_frame_idx = sof_frame;
        end
      end else if (micro_idx != 3'h7) begin
        next_micro_idx = micro_idx + 3'h1;
      end
    end
    next_irq = |(flags & ien[7:1]) | |(endpoint_irq & ien[14:8]) |
               |(dma_irq & ien[30:25]);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl      <= `UHD_CTRL_RESET;
      ien       <= `UHD_IEN_RESET;
      flags     <= 7'h00;
      frame_idx <= 11'h000;
      micro_idx <= 3'h0;
      crc_err   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      ien       <= next_ien;
      flags     <= next_flags;
      frame_idx <= next_frame_idx;
      micro_idx <= next_micro_idx;
      crc_err   <= next_crc_err;
      irq       <= next_irq;
    end
  end

  // remote wakeup: wait out the suspend time, then drive k
  always_comb begin
    next_wk       = wk;
    next_k_cnt    = k_cnt;
    wake_done     = 1'b0;
    next_susp_cnt = !bus_suspended ? 24'h00_0000 :
                    susp_cnt == 24'hFF_FFFF ? susp_cnt : susp_cnt + 24'h00_0001;
    if (!ctrl[`UHD_EN_BIT]) begin
      next_wk = WK_IDLE;
    end else begin
      unique case (wk)
        WK_IDLE: if (ctrl[`UHD_RWU_BIT]) begin
          next_wk = WK_WAIT;
        end
        WK_WAIT: if (!bus_suspended) begin
          // host resumed first; nothing left to send
          next_wk   = WK_IDLE;
          wake_done = 1'b1;
        end else if (susp_cnt >= SUSP_W) begin
          next_wk    = WK_DRIVE;
          next_k_cnt = 24'h00_0000;
        end
        WK_DRIVE: if (k_cnt == K_LAST) begin
          next_wk   = WK_IDLE;
          wake_done = 1'b1;
        end else begin
          next_k_cnt = k_cnt + 24'h00_0001;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wk       <= WK_IDLE;
      susp_cnt <= 24'h00_0000;
      k_cnt    <= 24'h00_0000;
      susp_q   <= 1'b0;
      wake_s1  <= 1'b0;
      wake_s2  <= 1'b0;
      wake_s3  <= 1'b0;
    end else begin
      wk       <= next_wk;
      susp_cnt <= next_susp_cnt;
      k_cnt    <= next_k_cnt;
      susp_q   <= bus_suspended;
      wake_s1  <= line_wake_async;     // only wake_s2 reads this
      wake_s2  <= wake_s1;
      wake_s3  <= wake_s2;
    end
  end

  chk_addr_bus_reset: assert property (@(posedge mclk) disable iff (reset)
    bus_reset_done |=> ctrl[6:0] == 7'h00 && !ctrl[`UHD_AVALID_BIT])
    else $error("address not cleared by bus reset");
  chk_default_addr: assert property (@(posedge mclk) disable iff (reset)
    !ctrl[`UHD_AVALID_BIT] && token_addr != 7'h00 |-> !addr_match)
    else $error("nonzero address accepted before address state");
  chk_enable_write: assert property (@(posedge mclk) disable iff (reset)
    wr_ctrl && rb.wr_strb[1] |=> controller_enable == $past(rb.wr_data[8]))
    else $error("enable bit not taken from write");
  chk_detach_pins: assert property (@(posedge mclk) disable iff (reset)
    xcvr_suspend |-> !dp_pullup)
    else $error("pull-up on while detached");
  chk_resume_late: assert property (@(posedge mclk) disable iff (reset)
    $rose(resume_k) |-> $past(susp_cnt) >= SUSP_W && $past(bus_suspended))
    else $error("resume started early");
  chk_wake_clear: assert property (@(posedge mclk) disable iff (reset)
    $fell(resume_k) && !$past(wr_ctrl) |-> !ctrl[`UHD_RWU_BIT])
    else $error("wakeup request not retired");
  chk_line_float: assert property (@(posedge mclk) disable iff (reset)
    ctrl[`UHD_PDOFF_BIT] |-> !dp_pulldown && !dm_pulldown &&
                             (!ctrl[`UHD_DETACH_BIT] || !dp_pullup))
    else $error("line driven while floating asked");
  chk_micro_zero: assert property (@(posedge mclk) disable iff (reset)
    sof_valid && sof_first ##1 !sof_valid |=> micro_idx == 3'h0)
    else $error("microframe index not zeroed");
  chk_frame_load: assert property (@(posedge mclk) disable iff (reset)
    controller_enable && sof_valid && sof_first && !sof_crc_err
      |=> frame_idx == $past(sof_frame))
    else $error("frame number not loaded");
  chk_crc_with_sof: assert property (@(posedge mclk) disable iff (reset)
    controller_enable && sof_valid |=> crc_err == $past(sof_crc_err) &&
                                      (flags[3] || flags[2]))
    else $error("crc flag not with sof flag");
  chk_reset_ien: assert property (@(posedge mclk) disable iff (reset)
    bus_reset_done |=> ien[`UHD_IEN_RST_BIT])
    else $error("end-of-reset enable not set");
  chk_irq_follow: assert property (@(posedge mclk) disable iff (reset)
    ##1 irq == $past(|(flags & ien[7:1]) | |(endpoint_irq & ien[14:8]) |
                     |(dma_irq & ien[30:25])))
    else $error("interrupt line wrong");
  chk_set_wins: assert property (@(posedge mclk) disable iff (reset)
    ev_set[3] && ev_clr[3] |=> flags[3])
    else $error("event lost against clear");
endmodule : uhd_global_ctrl

// [design/uhd_consts.svh]
// constants of the usb device global control slice
// assumes byte addresses on an 8-bit axi4-lite offset and a 250 MHz mclk
`ifndef UHD_CONSTS_SVH
`define UHD_CONSTS_SVH
// register byte offsets
`define UHD_OFS_CTRL    8'h00
`define UHD_OFS_FRAME   8'h04
`define UHD_OFS_IEN     8'h10
`define UHD_OFS_STAT    8'h14
`define UHD_OFS_CLR     8'h18
// device_control fields
`define UHD_ADDR_LSB    0
`define UHD_ADDR_MSB    6
`define UHD_AVALID_BIT  7
`define UHD_EN_BIT      8
`define UHD_DETACH_BIT  9
`define UHD_RWU_BIT     10
`define UHD_PDOFF_BIT   11
`define UHD_CTRL_RESET  12'h200
`define UHD_CTRL_WMASK  32'h0000_0FFF
// frame_number fields
`define UHD_MICRO_LSB   0
`define UHD_FRAME_LSB   3
`define UHD_CRCERR_BIT  31
// interrupt_enable fields
`define UHD_IEN_RESET   32'h0000_0010
`define UHD_IEN_MASK    32'h7E00_7FFE
`define UHD_IEN_RST_BIT 4
// axi responses
`define UHD_RESP_OKAY   2'h0
`define UHD_RESP_SLVERR 2'h2
// timing: ms figures and the clock rate in kHz
`define UHD_CLK_KHZ     250000
`define UHD_SUSP_MS     5
`define UHD_RESUME_MS   2
`define UHD_SUSP_CYC    (`UHD_SUSP_MS * `UHD_CLK_KHZ)
`define UHD_RESUME_CYC  (`UHD_RESUME_MS * `UHD_CLK_KHZ)
`endif

// [design/uhd_pkg.sv]
// types shared by the usb device global control slice
// assumes nothing beyond the constants header
package uhd_pkg;
  // remote wakeup sequencer
  typedef enum logic [1:0] {WK_IDLE, WK_WAIT, WK_DRIVE} uhd_wake_e;
  typedef logic [31:0] uhd_word_t;
endpackage : uhd_pkg

// [design/uhd_regbus_if.sv]
// internal register access port between bus slave and register file
// assumes one clock domain; reads are answered combinationally
`timescale 1ns/1ps
interface uhd_regbus_if;
  logic        wr_en;   // one-cycle write pulse
  logic [7:0]  wr_addr; // write byte address
  logic [31:0] wr_data; // write data
  logic [3:0]  wr_strb; // byte enables
  logic        wr_err;  // unmapped write
  logic [7:0]  rd_addr; // read byte address
  logic [31:0] rd_data; // read data
  logic        rd_err;  // unmapped read
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : uhd_regbus_if

// [design/uhd_axil_slave.sv]
// axi4-lite slave front end for the global control registers
// assumes a master per the amba rules; one write and one read at a time
`timescale 1ns/1ps
`include "uhd_consts.svh"
module uhd_axil_slave
  import uhd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  uhd_regbus_if.bus        rb
);
  logic        aw_have, next_aw_have;   // address held
  logic        w_have,  next_w_have;    // data held
  logic [7:0]  aw_addr, next_aw_addr;
  uhd_word_t   w_data,  next_w_data;
  logic [3:0]  w_strb,  next_w_strb;
  logic        bv,      next_bv;        // write answer pending
  logic [1:0]  br,      next_br;
  logic        rv,      next_rv;        // read answer pending
  uhd_word_t   rd,      next_rd;
  logic [1:0]  rr,      next_rr;

  // channels stall while their slot is full or an answer waits
  assign awready    = !aw_have && !bv;
  assign wready     = !w_have && !bv;
  assign arready    = !rv;
  assign bvalid     = bv;
  assign bresp      = br;
  assign rvalid     = rv;
  assign rdata      = rd;
  assign rresp      = rr;
  assign rb.wr_en   = aw_have && w_have && !bv;
  assign rb.wr_addr = aw_addr;
  assign rb.wr_data = w_data;
  assign rb.wr_strb = w_strb;
  // read decode is combinational, so the address need not be held
  assign rb.rd_addr = araddr;

  // next state of both channels
  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bv      = bv;
    next_br      = br;
    next_rv      = rv;
    next_rd      = rd;
    next_rr      = rr;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (rb.wr_en) begin
      // both halves in: commit and answer
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bv      = 1'b1;
      next_br      = rb.wr_err ? `UHD_RESP_SLVERR : `UHD_RESP_OKAY;
    end else if (bv && bready) begin
      next_bv = 1'b0;
    end
    if (arvalid && arready) begin
      next_rv = 1'b1;
      next_rd = rb.rd_data;
      next_rr = rb.rd_err ? `UHD_RESP_SLVERR : `UHD_RESP_OKAY;
    end else if (rv && rready) begin
      next_rv = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bv      <= 1'b0;
      br      <= `UHD_RESP_OKAY;
      rv      <= 1'b0;
      rd      <= 32'h0000_0000;
      rr      <= `UHD_RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      w_have  <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bv      <= next_bv;
      br      <= next_br;
      rv      <= next_rv;
      rd      <= next_rd;
      rr      <= next_rr;
    end
  end
endmodule : uhd_axil_slave

// [tb/uhd_link_model.sv]
// usb side stand-in: decoder strobes for sof and end of bus reset
// assumes the slice samples them on rising mclk, one cycle each
`timescale 1ns/1ps
module uhd_link_model (
  input  wire logic        mclk,
  output logic             rst_done, // end of bus reset pulse
  output logic             sof_v,    // sof strobe
  output logic             sof_f,    // first sof of a frame
  output logic [10:0]      sof_n,    // frame number
  output logic             sof_e     // corrupted number
);
  initial {rst_done, sof_v, sof_f, sof_n, sof_e} = '0;
  // one-cycle strobe; fields inverted after so no stale value lingers
  task automatic sof(input logic f, input logic [10:0] n, input logic e);
    @(posedge mclk);
    {sof_v, sof_f, sof_n, sof_e} <= {1'b1, f, n, e};
    @(posedge mclk);
    {sof_v, sof_f, sof_n, sof_e} <= {1'b0, !f, ~n, !e};
  endtask : sof
  // end of bus reset, a single pulse
  task automatic bus_rst();
    @(posedge mclk);
    rst_done <= 1'b1;
    @(posedge mclk);
    rst_done <= 1'b0;
  endtask : bus_rst
endmodule : uhd_link_model

// [tb/tb_usb_hs_device_global_control.sv]
// bench for the usb device global control slice
// assumes the link model drives sof and bus reset strobes
`timescale 1ns/1ps
`include "uhd_consts.svh"
module tb_usb_hs_device_global_control import uhd_pkg::*;;
  localparam int SW = 20; // short suspend wait
  localparam int RK = 10; // short k length
  logic mclk = 1'b0, reset = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic bsus, am, en, sus, pu, dpd, dmd, rk, irq, rdn, sv, sf, se;
  logic [10:0] sn, f;
  logic [6:0] tok, ep;
  logic [33:0] q[$];           // expected answers, oldest first
  int fails = 0, samples_checked = 0, c, n;
  logic [31:0] seed = 32'h0000_005A; // xorshift state
  always #2 mclk = ~mclk;
  uhd_link_model uhd_link_model_inst (.mclk, .rst_done(rdn), .sof_v(sv), .sof_f(sf),
    .sof_n(sn), .sof_e(se));
  uhd_global_ctrl #(.SUSP_WAIT_CYC(SW), .RESUME_K_CYC(RK)) uhd_global_ctrl_inst (.mclk,
    .reset, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus_reset_done(rdn), .bus_suspended(bsus), .high_speed(1'b1), .sof_valid(sv),
    .sof_first(sf), .sof_frame(sn), .sof_crc_err(se), .resume_done(1'b0),
    .line_wake_async(1'b0), .token_addr(tok), .endpoint_irq(ep), .dma_irq(6'(ep)),
    .addr_match(am), .controller_enable(en), .xcvr_suspend(sus), .dp_pullup(pu),
    .dp_pulldown(dpd), .dm_pulldown(dmd), .resume_k(rk), .irq);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic ck(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : ck
  // a used-up wait bound ends the run as a failure
  task automatic tmo(input int k);
    if (k >= 50) begin
      fails++;
      stop_test();
    end
  endtask : tmo
  // write: each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rs);
    int k;
    q.push_back({rs, 32'h0});
    @(posedge mclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hF, 3'b111};
    // the edge that shows bvalid high is the response handshake
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    tmo(k);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    q.push_back(e);
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    // the edge that shows rvalid high takes the read data
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    tmo(k);
  endtask : rd
  // port levels, looked at where settled
  task automatic ckp(input logic [6:0] e);
    @(negedge mclk);
    ck({27'h0, irq, am, en, sus, pu, dpd, dmd}, {27'h0, e});
    // back on the rising edge so later stimulus lands there
    @(posedge mclk);
  endtask : ckp
  // pairs each bus answer with the oldest noted expectation
  always @(posedge mclk) begin
    if (bvalid && bready) ck({bresp, 32'h0}, q.pop_front());
    if (rvalid && rready) ck({rresp, rdata}, q.pop_front());
  end
  initial begin
    {awaddr, araddr, wdata, wstrb, tok, bsus} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ep = 7'(rnd());
    f = 11'(rnd());
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(`UHD_OFS_CTRL, 34'h0_0000_0200);
    rd(`UHD_OFS_FRAME, 34'h0);
    rd(`UHD_OFS_IEN, 34'h0_0000_0010);
    rd(8'h08, 34'h2_0000_0000);
    wr(8'h08, 32'hFFFF_FFFF, 2'h2);
    ckp(7'b0101011);
    for (int i = 0; i < 4; i++) begin
      d = rnd() & 32'hFFFF_F1FF | {20'h0, i[1], 1'b0, i[0], 9'h0};
      wr(`UHD_OFS_CTRL, d, 2'h0);
      rd(`UHD_OFS_CTRL, {2'h0, d & 32'h0000_0BFF});
      ckp({1'b0, !d[7] || d[6:0] == 7'h0, d[8], d[9], !d[9], {2{d[9] && !d[11]}}});
    end
    d = {24'h1, 1'b1, 7'(rnd() | 1)};
    wr(`UHD_OFS_CTRL, d, 2'h0);
    wr(`UHD_OFS_IEN, 32'h0, 2'h0);
    tok <= d[6:0];
    ckp(7'b0110100);
    tok <= 7'h0;
    ckp(7'b0010100);
    uhd_link_model_inst.bus_rst();
    rd(`UHD_OFS_CTRL, 34'h0_0000_0100);
    rd(`UHD_OFS_IEN, 34'h0_0000_0010);
    ckp(7'b1110100);
    d = rnd();
    wr(`UHD_OFS_IEN, d, 2'h0);
    rd(`UHD_OFS_IEN, {2'h0, d & 32'h7E00_7FFE});
    wr(`UHD_OFS_CLR, 32'h0000_00FE, 2'h0);
    wr(`UHD_OFS_IEN, 32'h0000_0008, 2'h0);
    ckp(7'b0110100);
    uhd_link_model_inst.sof(1'b1, f, 1'b0);
    repeat (3) uhd_link_model_inst.sof(1'b0, f, 1'b0);
    rd(`UHD_OFS_FRAME, {20'h0, f, 3'h3});
    ckp(7'b1110100);
    uhd_link_model_inst.sof(1'b1, f + 11'h1, 1'b1);
    rd(`UHD_OFS_FRAME, {3'h1, 17'h0, f, 3'h0});
    wr(`UHD_OFS_CLR, 32'h0, 2'h0);
    ckp(7'b1110100);
    wr(`UHD_OFS_CLR, 32'h0000_0008, 2'h0);
    rd(`UHD_OFS_IEN, 34'h0_0000_0008);
    ckp(7'b0110100);
    // frame start lands in the cycle the clear commits: the set must win
    fork
      wr(`UHD_OFS_CLR, 32'h0000_0008, 2'h0);
      begin
        @(posedge mclk);
        uhd_link_model_inst.sof(1'b1, f, 1'b0);
      end
    join
    ckp(7'b1110100);
    bsus <= 1'b1;
    wr(`UHD_OFS_CTRL, 32'h0000_0500, 2'h0);
    for (c = 0; c < 50 && rk !== 1'b1; c++) @(negedge mclk);
    tmo(c);
    ck({33'h0, c >= SW - 8}, 34'h1);
    for (n = 0; n < 50 && rk === 1'b1; n++) @(negedge mclk);
    tmo(n);
    ck(34'(n), 34'(RK));
    rd(`UHD_OFS_CTRL, 34'h0_0000_0100);
    stop_test();
  end
endmodule : tb_usb_hs_device_global_control
